/* File: tstc_pkg.sv */
package tstc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned TIME_W = 7;
  localparam int unsigned CMP_W = 9;
  localparam int unsigned ERR_W = 24;
  localparam int unsigned ERR_LO_W = 8;
  localparam int unsigned ERR_HI_W = 16;

  // bank-0 slots, then bank-1 high word and a status word
  localparam logic [7:0] OFF_SLOT0 = 8'h00;
  localparam logic [7:0] OFF_SLOT1 = 8'h04;
  localparam logic [7:0] OFF_SLOT2 = 8'h08;
  localparam logic [7:0] OFF_SLOT3 = 8'h0C;
  localparam logic [7:0] OFF_SLOT4 = 8'h10;
  localparam logic [7:0] OFF_SLOT5 = 8'h14;
  localparam logic [7:0] OFF_ERR_LO = 8'h18;
  localparam logic [7:0] OFF_SW_TIMING = 8'h1C;
  localparam logic [7:0] OFF_ERR_HI = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;

  // antenna_switch_timing fields
  localparam int unsigned POL_BIT = 15;
  localparam int unsigned ON_MSB = 14;
  localparam int unsigned ON_LSB = 8;
  localparam int unsigned OFF_MSB = 6;
  localparam int unsigned OFF_LSB = 0;
  localparam int unsigned LANE_LO = 0;
  localparam int unsigned LANE_HI = 1;

  // status fields
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_HANDSET_BIT = 1;

  // fixed upper compare bits by role
  localparam logic [1:0] ON_HI_BASE = 2'h0;
  localparam logic [1:0] ON_HI_HANDSET = 2'h1;
  localparam logic [1:0] OFF_HI_BASE = 2'h1;
  localparam logic [1:0] OFF_HI_HANDSET = 2'h2;

  localparam logic RST_POL = 1'h0;
  localparam logic [6:0] RST_TIME = 7'h00;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
endpackage : tstc_pkg

/* File: tstc_top.sv */
`timescale 1ns/100ps
// What this block does
// - polarity bit inverts both switch outputs
// - bits 14..8 set turn-on time
// - bits 6..0 set turn-off time
// - programmed field is (x mod 128) minus one
// - nine-bit compare, two upper bits fixed
// - turn-on upper bits 00 base, 01 handset
// - turn-off upper bits 01 base, 10 handset
// - compare against transmit frame counter
// - field writes take effect at once
// - low error byte readable, writes ignored
// - upper sixteen error bits in bank-1 register
module tstc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tstc_pkg::ADDR_W-1:0] paddr,
  input wire logic [tstc_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [tstc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [tstc_pkg::CMP_W-1:0] tx_frame_count,
  input wire logic handset_mode,
  input wire logic [tstc_pkg::ERR_W-1:0] sym_err,
  output logic transmit_switch_out,
  output logic receive_switch_out
);

  function automatic logic tstc_mapped(input logic [7:0] a);
    return (a <= tstc_pkg::OFF_STATUS) && (a[1:0] == 2'h0);
  endfunction : tstc_mapped

  logic switch_polarity_invert;
  logic [tstc_pkg::TIME_W-1:0] switch_turn_on_time;
  logic [tstc_pkg::TIME_W-1:0] switch_turn_off_time;
  logic tx_active;
  logic next_switch_polarity_invert;
  logic [tstc_pkg::TIME_W-1:0] next_switch_turn_on_time;
  logic [tstc_pkg::TIME_W-1:0] next_switch_turn_off_time;
  logic next_tx_active;
  logic next_transmit_switch_out;
  logic next_receive_switch_out;
  logic [tstc_pkg::DATA_W-1:0] next_prdata;
  logic [tstc_pkg::CMP_W-1:0] on_cmp;
  logic [tstc_pkg::CMP_W-1:0] off_cmp;
  logic wr_timing;
  logic rd_setup;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !tstc_mapped(paddr);
  assign wr_timing = psel && penable && pwrite
    && (paddr == tstc_pkg::OFF_SW_TIMING);
  assign rd_setup = psel && !penable && !pwrite;

  // register writes; only the timing word holds state
  always_comb begin
    next_switch_polarity_invert = switch_polarity_invert;
    next_switch_turn_on_time = switch_turn_on_time;
    next_switch_turn_off_time = switch_turn_off_time;
    if (wr_timing && pstrb[tstc_pkg::LANE_HI]) begin
      next_switch_polarity_invert = pwdata[tstc_pkg::POL_BIT];
      next_switch_turn_on_time =
        pwdata[tstc_pkg::ON_MSB:tstc_pkg::ON_LSB];
    end
    if (wr_timing && pstrb[tstc_pkg::LANE_LO]) begin
      next_switch_turn_off_time =
        pwdata[tstc_pkg::OFF_MSB:tstc_pkg::OFF_LSB];
    end
  end

  // compare values: fixed role bits over programmed field
  always_comb begin
    on_cmp = {handset_mode ? tstc_pkg::ON_HI_HANDSET
                           : tstc_pkg::ON_HI_BASE,
              switch_turn_on_time};
    off_cmp = {handset_mode ? tstc_pkg::OFF_HI_HANDSET
                            : tstc_pkg::OFF_HI_BASE,
               switch_turn_off_time};
  end

  // switch state; off match wins when both match
  always_comb begin
    next_tx_active = tx_active;
    if (tx_frame_count == off_cmp) begin
      next_tx_active = 1'b0;
    end else if (tx_frame_count == on_cmp) begin
      next_tx_active = 1'b1;
    end
    // new polarity reaches the pins at the write edge
    next_transmit_switch_out = next_switch_polarity_invert
      ? next_tx_active : !next_tx_active;
    next_receive_switch_out = !next_transmit_switch_out;
  end

  // read data captured in the setup phase
  always_comb begin
    next_prdata = prdata;
    if (rd_setup) begin
      next_prdata = tstc_pkg::ZERO_WORD;
      unique case (paddr)
        tstc_pkg::OFF_ERR_LO:
          next_prdata[tstc_pkg::ERR_LO_W-1:0] =
            sym_err[tstc_pkg::ERR_LO_W-1:0];
        tstc_pkg::OFF_ERR_HI:
          next_prdata[tstc_pkg::ERR_HI_W-1:0] =
            sym_err[tstc_pkg::ERR_W-1:tstc_pkg::ERR_LO_W];
        tstc_pkg::OFF_STATUS: begin
          next_prdata[tstc_pkg::STAT_ACTIVE_BIT] = tx_active;
          next_prdata[tstc_pkg::STAT_HANDSET_BIT] = handset_mode;
        end
        default: begin
          next_prdata = tstc_pkg::ZERO_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_polarity_invert <= tstc_pkg::RST_POL;
      switch_turn_on_time <= tstc_pkg::RST_TIME;
      switch_turn_off_time <= tstc_pkg::RST_TIME;
      tx_active <= 1'b0;
      transmit_switch_out <= !tstc_pkg::RST_POL;
      receive_switch_out <= tstc_pkg::RST_POL;
      prdata <= tstc_pkg::ZERO_WORD;
    end else begin
      switch_polarity_invert <= next_switch_polarity_invert;
      switch_turn_on_time <= next_switch_turn_on_time;
      switch_turn_off_time <= next_switch_turn_off_time;
      tx_active <= next_tx_active;
      transmit_switch_out <= next_transmit_switch_out;
      receive_switch_out <= next_receive_switch_out;
      prdata <= next_prdata;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pol_write;
    wr_timing && pstrb[1] |=> switch_polarity_invert == $past(pwdata[15])
      && transmit_switch_out == ($past(pwdata[15]) ? tx_active : !tx_active);
  endproperty
  a_pol_write: assert property (p_pol_write)
    else $error("polarity write not applied at once");

  property p_pins_opposite;
    receive_switch_out != transmit_switch_out;
  endproperty
  a_pins_opposite: assert property (p_pins_opposite)
    else $error("switch outputs not complementary");

  property p_on_field;
    wr_timing && pstrb[1] |=> switch_turn_on_time == $past(pwdata[14:8]);
  endproperty
  a_on_field: assert property (p_on_field)
    else $error("turn-on field not stored");

  property p_off_field;
    wr_timing && pstrb[0] |=> switch_turn_off_time == $past(pwdata[6:0]);
  endproperty
  a_off_field: assert property (p_off_field)
    else $error("turn-off field not stored");

  property p_on_match;
    tx_frame_count[6:0] == switch_turn_on_time
      && tx_frame_count[8:7] == (handset_mode ? 2'h1 : 2'h0)
      && tx_frame_count != off_cmp
      |=> tx_active ##1 tx_active || $past(tx_frame_count) == off_cmp;
  endproperty
  a_on_match: assert property (p_on_match)
    else $error("switch not on at turn-on match");

  property p_off_match;
    tx_frame_count[6:0] == switch_turn_off_time
      && tx_frame_count[8:7] == (handset_mode ? 2'h2 : 2'h1)
      |=> !tx_active;
  endproperty
  a_off_match: assert property (p_off_match)
    else $error("switch not off at turn-off match");

  property p_hold;
    tx_frame_count != on_cmp && tx_frame_count != off_cmp
      |=> $stable(tx_active);
  endproperty
  a_hold: assert property (p_hold)
    else $error("switch changed without counter match");

  property p_err_lo;
    rd_setup && paddr == tstc_pkg::OFF_ERR_LO
      |=> prdata == {24'h000000, $past(sym_err[7:0])};
  endproperty
  a_err_lo: assert property (p_err_lo)
    else $error("low error byte read wrong");

  property p_err_hi;
    rd_setup && paddr == tstc_pkg::OFF_ERR_HI
      |=> prdata == {16'h0000, $past(sym_err[23:8])};
  endproperty
  a_err_hi: assert property (p_err_hi)
    else $error("high error word read wrong");

  property p_rsvd_zero;
    rd_setup && (paddr <= tstc_pkg::OFF_SLOT5
      || paddr == tstc_pkg::OFF_SW_TIMING) |=> prdata == 32'h00000000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved or write-only register read nonzero");

  // bus response
  property p_slverr_unmapped;
    psel && penable && paddr > tstc_pkg::OFF_STATUS
      |-> pslverr;
  endproperty
  a_slverr_unmapped: assert property (p_slverr_unmapped)
    else $error("unmapped access not flagged");

  property p_slverr_unaligned;
    psel && penable && paddr[1:0] != 2'h0
      |-> pslverr;
  endproperty
  a_slverr_unaligned: assert property (p_slverr_unaligned)
    else $error("unaligned access not flagged");

  property p_slverr_mapped;
    psel && penable && paddr <= tstc_pkg::OFF_STATUS
      && paddr[1:0] == 2'h0
      |-> !pslverr;
  endproperty
  a_slverr_mapped: assert property (p_slverr_mapped)
    else $error("mapped access flagged as error");

  property p_slverr_idle;
    !(psel && penable) |-> !pslverr;
  endproperty
  a_slverr_idle: assert property (p_slverr_idle)
    else $error("error flag outside access phase");

  // read path
  property p_prdata_hold;
    !rd_setup |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold)
    else $error("read data changed without read");

  property p_status_read;
    rd_setup && paddr == tstc_pkg::OFF_STATUS
      |=> prdata == {30'h00000000, $past(handset_mode),
        $past(tx_active)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status word read wrong");

  property p_read_state;
    rd_setup
      |=> $stable(switch_polarity_invert)
        && $stable(switch_turn_on_time)
        && $stable(switch_turn_off_time);
  endproperty
  a_read_state: assert property (p_read_state)
    else $error("read disturbed timing fields");

  // field registers change only on their own write
  property p_on_hold;
    !(wr_timing && pstrb[tstc_pkg::LANE_HI])
      |=> $stable(switch_polarity_invert)
        && $stable(switch_turn_on_time);
  endproperty
  a_on_hold: assert property (p_on_hold)
    else $error("turn-on or polarity changed without write");

  property p_off_hold;
    !(wr_timing && pstrb[tstc_pkg::LANE_LO])
      |=> $stable(switch_turn_off_time);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("turn-off changed without write");

  property p_other_write;
    psel && penable && pwrite && paddr != tstc_pkg::OFF_SW_TIMING
      |=> $stable(switch_polarity_invert)
        && $stable(switch_turn_on_time)
        && $stable(switch_turn_off_time);
  endproperty
  a_other_write: assert property (p_other_write)
    else $error("write to other register changed timing");

  // pin levels against switch state
  property p_tx_level;
    transmit_switch_out
      == (switch_polarity_invert ? tx_active : !tx_active);
  endproperty
  a_tx_level: assert property (p_tx_level)
    else $error("transmit switch level wrong");

  property p_rx_level;
    receive_switch_out
      == (switch_polarity_invert ? !tx_active : tx_active);
  endproperty
  a_rx_level: assert property (p_rx_level)
    else $error("receive switch level wrong");

  property p_pins_hold;
    tx_frame_count != on_cmp && tx_frame_count != off_cmp
      && !(wr_timing && pstrb[tstc_pkg::LANE_HI])
      |=> $stable(transmit_switch_out);
  endproperty
  a_pins_hold: assert property (p_pins_hold)
    else $error("switch pin moved without match or write");

  // switch state moves only on a compare match
  property p_rise_cause;
    $rose(tx_active)
      |-> $past(tx_frame_count) == $past(on_cmp);
  endproperty
  a_rise_cause: assert property (p_rise_cause)
    else $error("switch turned on without turn-on match");

  property p_fall_cause;
    $fell(tx_active)
      |-> $past(tx_frame_count) == $past(off_cmp);
  endproperty
  a_fall_cause: assert property (p_fall_cause)
    else $error("switch turned off without turn-off match");

  c_turn_on: cover property (!tx_active ##1 tx_active);
  c_turn_off: cover property (tx_active ##1 !tx_active);
  c_pol_flip: cover property (wr_timing && pstrb[1] && pwdata[15]);
  c_err_read: cover property (rd_setup && paddr == 8'h18);
  c_hs_on: cover property (handset_mode && !tx_active ##1 tx_active);

endmodule : tstc_top

/* File: tstc_ant_model.sv */
`timescale 1ns/100ps
module tstc_ant_model (
  input wire logic tx_sw,
  input wire logic rx_sw,
  output logic conflict
);
  // equal pins would leave the antenna half switched
  assign conflict = (tx_sw === rx_sw);
endmodule : tstc_ant_model

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, r;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, e, hs = 0, txo, rxo, conflict, chk = 0, act = 0;
  logic [8:0] cnt = 9'h000;
  logic [23:0] err = 24'h000000;
  int bad_count = 0, n_compared = 0, onc, offc, pol, x, onv, offv;
  tstc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_frame_count(cnt), .handset_mode(hs), .sym_err(err),
    .transmit_switch_out(txo), .receive_switch_out(rxo));
  tstc_ant_model ant (.tx_sw(txo), .rx_sw(rxo), .conflict(conflict));
  initial forever #2 pclk = ~pclk;
  task automatic tally_and_finish;
    $display("counts: compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [31:0] g, input logic [31:0] t, string m);
    n_compared++;
    if (g !== t) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, t);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50) begin
      bad_count++;
      $display("BAD %0t apb hang", $time);
      tally_and_finish();
    end
  endtask : apb
  // reference switch state, off match wins
  always @(posedge pclk or negedge presetn)
    if (!presetn) act <= 0;
    else if (cnt == offc) act <= 0;
    else if (cnt == onc) act <= 1;
  always @(negedge pclk) if (chk) begin
    cmp(txo, pol ? act : !act, "transmit_switch_out");
    cmp(rxo, pol ? !act : act, "receive_switch_out");
    cmp(conflict, 0, "pins equal");
  end
  initial begin
    x = $urandom(32'h083D);
    repeat (8) @(posedge pclk);
    cmp({txo, rxo}, 2'h2, "reset pins");
    presetn <= 1;
    for (int i = 0; i < 8; i++) begin
      hs <= i[0];
      pol = i[1];
      x = $urandom % 512;
      onv = ((x % 128) + 127) % 128;
      x = $urandom % 512;
      offv = ((x % 128) + 127) % 128;
      onc = (i[0] ? 128 : 0) + onv;
      offc = (i[0] ? 256 : 128) + offv;
      apb(1, tstc_pkg::OFF_SW_TIMING,
        {16'h0000, pol[0], onv[6:0], 1'b0, offv[6:0]});
      for (int k = 0; k < 514; k++) begin
        @(posedge pclk);
        chk = (k > 0);
        cnt <= 9'(offc + k);
      end
      chk = 0;
      err <= 24'($urandom);
      apb(0, tstc_pkg::OFF_ERR_LO, 32'h00000000);
      cmp(r, {24'h000000, err[7:0]}, "err lo");
      apb(0, tstc_pkg::OFF_ERR_HI, 32'h00000000);
      cmp(r, {16'h0000, err[23:8]}, "err hi");
      $display("test %0d done", i);
    end
    for (int a = 0; a < 8; a++) begin
      apb(1, 8'(a * 4), 32'hFFFFFFFF);
      apb(0, 8'(a * 4), 32'h00000000);
      cmp(r, a == 6 ? {24'h000000, err[7:0]} : 32'h0, "rsvd");
    end
    pol = 1;
    onc = 128 + 127;
    offc = 256 + 127;
    for (int s = 0; s < 2; s++) begin
      @(posedge pclk);
      cnt <= 9'(s ? onc : offc);
      repeat (2) @(posedge pclk);
      apb(0, tstc_pkg::OFF_STATUS, 32'h00000000);
      cmp(r, {30'h00000000, hs, act}, "status");
      cmp(txo, pol ? act : !act, "transmit_switch_out hold");
    end
    apb(0, 8'h28, 32'h00000000);
    cmp({e, r[30:0]}, 32'h80000000, "unmapped");
    apb(0, 8'h1A, 32'h00000000);
    cmp({e, r[30:0]}, 32'h80000000, "unaligned");
    $display("test registers done");
    tally_and_finish();
  end
endmodule : tb_top
